/* hdl/adccs_defines.svh */
// constants of the converter calibration coefficient store
`ifndef ADCCS_DEFINES_SVH
`define ADCCS_DEFINES_SVH

// register addresses on the special function register port
`define ADCCS_ADDR_OFS_LOW   8'hA0
`define ADCCS_ADDR_OFS_MID   8'hA1
`define ADCCS_ADDR_OFS_HIGH  8'hA2
`define ADCCS_ADDR_GAIN_LOW  8'hA3
`define ADCCS_ADDR_GAIN_MID  8'hA4
`define ADCCS_ADDR_GAIN_HIGH 8'hA5

// byte index of an unmapped address, and what it reads as
`define ADCCS_IDX_NONE       3'h7
`define ADCCS_RD_UNMAPPED    8'h00

// reset values: zero offset, unity gain
`define ADCCS_OFFSET_RST     24'h000000
`define ADCCS_GAIN_RST       24'h800000

// coefficient limits
`define ADCCS_OFFSET_POS_FS  24'h7FFFFF
`define ADCCS_OFFSET_NEG_FS  24'h800000
`define ADCCS_GAIN_MIN       24'h000000
`define ADCCS_GAIN_MAX       24'hFFFFFF

// fractional bits of the gain word
`define ADCCS_GAIN_FRAC      23

`endif

/* hdl/adccs_pkg.sv */
// types of the converter calibration coefficient store
package adccs_pkg;

   // one 24-bit calibration coefficient
   typedef logic [23:0] adccs_coef_t;

   // which coefficient a finished calibration produced
   typedef enum logic
   {
      ADCCS_CAL_OFFSET = 1'b0,
      ADCCS_CAL_GAIN   = 1'b1
   } adccs_cal_t;

endpackage : adccs_pkg

/* hdl/adccs_corr.sv */
// two-stage offset subtract and gain multiply of one conversion result
module adccs_corr
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // conversion result and coefficients
   input  wire logic                   in_valid_i,
   input  wire adccs_pkg::adccs_coef_t in_data_i,
   input  wire adccs_pkg::adccs_coef_t offset_i,
   input  wire adccs_pkg::adccs_coef_t gain_i,
   // full-width product, gain scaled by two to the 23rd
   output logic                        prod_valid_o,
   output logic signed [49:0]          prod_o
);
   import adccs_pkg::*;

   logic               stage_valid;
   logic signed [24:0] diff;
   logic signed [24:0] gain_s;
   logic               next_stage_valid;
   logic signed [24:0] next_diff;
   logic signed [24:0] next_gain_s;
   logic               next_prod_valid;
   logic signed [49:0] next_prod;

   // stage one: subtract offset, gain sampled with it so both belong to one result
   always_comb
   begin
      next_stage_valid = in_valid_i;
      next_diff        = diff;
      next_gain_s      = gain_s;
      if (in_valid_i)
      begin
         next_diff   = $signed({in_data_i[23], in_data_i}) -
                       $signed({offset_i[23], offset_i});
         next_gain_s = $signed({1'b0, gain_i});
      end
      next_prod_valid = stage_valid;
      next_prod       = stage_valid ? diff * gain_s : prod_o;
   end

   // registers of both stages
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stage_valid  <= 1'b0;
         diff         <= 25'h0;
         gain_s       <= 25'h0;
         prod_valid_o <= 1'b0;
         prod_o       <= 50'h0;
      end
      else
      begin
         stage_valid  <= next_stage_valid;
         diff         <= next_diff;
         gain_s       <= next_gain_s;
         prod_valid_o <= next_prod_valid;
         prod_o       <= next_prod;
      end
   end

endmodule : adccs_corr

/* hdl/adccs_store.sv */
// calibration coefficient store with register port and correction datapath
`include "adccs_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module adccs_store #(
   parameter int DATA_W = 24
)
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // special function register port
   input  wire logic [7:0]             sfr_addr_i,
   input  wire logic                   sfr_wr_i,
   input  wire logic [7:0]             sfr_wdata_i,
   input  wire logic                   sfr_rd_i,
   output logic [7:0]                  sfr_rdata_o,
   // calibration sequencer results
   input  wire logic                   cal_done_i,
   input  wire adccs_pkg::adccs_cal_t  cal_kind_i,
   input  wire adccs_pkg::adccs_coef_t cal_offset_i,
   input  wire logic [24:0]            cal_gain_i,
   // converter error
   input  wire logic                   err_clr_i,
   output logic                        converter_error_flag_o,
   // conversion datapath
   input  wire logic                   conv_valid_i,
   input  wire logic [DATA_W-1:0]      conv_data_i,
   output logic                        corr_valid_o,
   output logic [DATA_W-1:0]           corr_data_o,
   // stored coefficients
   output adccs_pkg::adccs_coef_t      offset_coef_o,
   output adccs_pkg::adccs_coef_t      gain_coef_o
);
   import adccs_pkg::*;

   localparam int          SHIFT   = 24 - DATA_W;
   localparam logic [47:0] RST_ALL = {`ADCCS_GAIN_RST, `ADCCS_OFFSET_RST};
   localparam adccs_coef_t OUT_MSK = 24'hFFFFFF << SHIFT;

   //////////////////////////////////////////////////////////////////////////
   // helpers

   // address to byte index, shared by read and write decode
   function automatic logic [2:0] addr_to_idx(input logic [7:0] a);
      case (a)
         `ADCCS_ADDR_OFS_LOW:   return 3'h0;
         `ADCCS_ADDR_OFS_MID:   return 3'h1;
         `ADCCS_ADDR_OFS_HIGH:  return 3'h2;
         `ADCCS_ADDR_GAIN_LOW:  return 3'h3;
         `ADCCS_ADDR_GAIN_MID:  return 3'h4;
         `ADCCS_ADDR_GAIN_HIGH: return 3'h5;
         default:               return `ADCCS_IDX_NONE;
      endcase
   endfunction : addr_to_idx

   // drop the gain fraction and saturate to a signed 24-bit code
   function automatic adccs_coef_t sat_shift(input logic signed [49:0] p);
      logic [26:0] s;
      s = 27'(p >>> `ADCCS_GAIN_FRAC);
      if (s[26:23] == 4'h0 || s[26:23] == 4'hF)
         return s[23:0];
      return s[26] ? 24'h800000 : 24'h7FFFFF;
   endfunction : sat_shift

   // reference of the whole correction, also used to check the pipeline
   function automatic adccs_coef_t corr_ref(input adccs_coef_t d,
                                             input adccs_coef_t o,
                                             input adccs_coef_t g);
      logic signed [24:0] df;
      logic signed [49:0] p;
      df = $signed({d[23], d}) - $signed({o[23], o});
      p  = df * $signed({1'b0, g});
      return sat_shift(p);
   endfunction : corr_ref

   //////////////////////////////////////////////////////////////////////////
   // coefficient bytes: 0..2 offset low..high, 3..5 gain low..high

   logic [7:0]  coef_byte      [6];
   logic [7:0]  next_coef_byte [6];
   logic [2:0]  wr_idx;
   logic [2:0]  rd_idx;
   logic [23:0] gain_clamped;
   logic [23:0] cal_word;
   logic        cal_at_limit;

   assign wr_idx = addr_to_idx(sfr_addr_i);
   assign rd_idx = addr_to_idx(sfr_addr_i);

   // clamp and limit check of the calibration result
   always_comb
   begin
      gain_clamped = (cal_gain_i > {1'b0, `ADCCS_GAIN_MAX}) ?
                     `ADCCS_GAIN_MAX : cal_gain_i[23:0];
      if (cal_kind_i == ADCCS_CAL_GAIN)
      begin
         cal_word     = gain_clamped;
         cal_at_limit = (gain_clamped == `ADCCS_GAIN_MIN) ||
                        (gain_clamped == `ADCCS_GAIN_MAX);
      end
      else
      begin
         cal_word     = cal_offset_i;
         cal_at_limit = (cal_offset_i == `ADCCS_OFFSET_POS_FS) ||
                        (cal_offset_i == `ADCCS_OFFSET_NEG_FS);
      end
   end

   // per byte: calibration load beats a software write in the same cycle
   for (genvar i = 0; i < 6; i++)
   begin : g_byte
      always_comb
      begin
         next_coef_byte[i] = coef_byte[i];
         if (cal_done_i && ((i >= 3) == (cal_kind_i == ADCCS_CAL_GAIN)))
            next_coef_byte[i] = cal_word[8*(i%3) +: 8];
         else if (sfr_wr_i && wr_idx == 3'(i))
            next_coef_byte[i] = sfr_wdata_i;
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            coef_byte[i] <= RST_ALL[8*i +: 8];
         else
            coef_byte[i] <= next_coef_byte[i];
      end
   end

   // coefficients straight from the byte flops
   assign offset_coef_o = {coef_byte[2], coef_byte[1], coef_byte[0]};
   assign gain_coef_o   = {coef_byte[5], coef_byte[4], coef_byte[3]};

   //////////////////////////////////////////////////////////////////////////
   // read data and error flag

   logic [7:0] next_rdata;
   logic       next_err;

   // read data holds between reads; unmapped addresses read as zero
   always_comb
   begin
      next_rdata = sfr_rdata_o;
      if (sfr_rd_i)
         next_rdata = (rd_idx < 3'h6) ? coef_byte[rd_idx] : `ADCCS_RD_UNMAPPED;
      // set wins so a limit hit coinciding with a clear is not lost
      next_err = (cal_done_i && cal_at_limit) ||
                 (converter_error_flag_o && !err_clr_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sfr_rdata_o            <= 8'h00;
         converter_error_flag_o <= 1'b0;
      end
      else
      begin
         sfr_rdata_o            <= next_rdata;
         converter_error_flag_o <= next_err;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // correction datapath

   adccs_coef_t        conv_aligned;
   logic               prod_valid;
   logic signed [49:0] prod;
   adccs_coef_t        prod_sat;
   logic               next_corr_valid;
   logic [DATA_W-1:0]  next_corr_data;

   // 16-bit codes sit above the eight fractional offset bits
   assign conv_aligned = 24'(conv_data_i) << SHIFT;

   adccs_corr u_corr
   (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .in_valid_i   (conv_valid_i),
      .in_data_i    (conv_aligned),
      .offset_i     (offset_coef_o),
      .gain_i       (gain_coef_o),
      .prod_valid_o (prod_valid),
      .prod_o       (prod)
   );

   // saturate; narrow variant drops the fraction bits again
   always_comb
   begin
      prod_sat        = sat_shift(prod);
      next_corr_valid = prod_valid;
      next_corr_data  = prod_valid ? prod_sat[23 -: DATA_W] : corr_data_o;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         corr_valid_o <= 1'b0;
         corr_data_o  <= '0;
      end
      else
      begin
         corr_valid_o <= next_corr_valid;
         corr_data_o  <= next_corr_data;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_conv_in;
      conv_valid_i;
   endsequence

   sequence s_corr_out;
      ##3 corr_valid_o;
   endsequence

   a_wr_offset_mid: assert property (
      sfr_wr_i && sfr_addr_i == `ADCCS_ADDR_OFS_MID && !cal_done_i
      |=> offset_coef_o[15:8] == $past(sfr_wdata_i))
      else $error("offset middle byte write lost");

   a_rd_gain_high: assert property (
      sfr_rd_i && sfr_addr_i == `ADCCS_ADDR_GAIN_HIGH
      |=> sfr_rdata_o == $past(gain_coef_o[23:16]))
      else $error("gain high byte read wrong");

   a_cal_offset_load: assert property (
      cal_done_i && cal_kind_i == ADCCS_CAL_OFFSET
      |=> offset_coef_o == $past(cal_offset_i) && $stable(gain_coef_o))
      else $error("offset calibration result not loaded");

   a_offset_fs_err: assert property (
      cal_done_i && cal_kind_i == ADCCS_CAL_OFFSET &&
      (cal_offset_i == `ADCCS_OFFSET_POS_FS || cal_offset_i == `ADCCS_OFFSET_NEG_FS)
      |=> converter_error_flag_o)
      else $error("offset full scale without error");

   a_gain_clamp_err: assert property (
      cal_done_i && cal_kind_i == ADCCS_CAL_GAIN && cal_gain_i[24]
      |=> gain_coef_o == `ADCCS_GAIN_MAX && converter_error_flag_o)
      else $error("gain not clamped or no error");

   a_err_cause: assert property (
      $rose(converter_error_flag_o) |-> $past(cal_done_i))
      else $error("error flag set without calibration");

   a_err_sticky: assert property (
      converter_error_flag_o && !err_clr_i |=> converter_error_flag_o)
      else $error("error flag dropped without clear");

   a_corr_latency: assert property (
      s_conv_in |-> s_corr_out)
      else $error("corrected result not after three cycles");

   a_corr_value: assert property (
      s_conv_in ##3 corr_valid_o |->
      ((24'(corr_data_o) << SHIFT) ==
       (corr_ref($past(conv_aligned, 3), $past(offset_coef_o, 3),
                 $past(gain_coef_o, 3)) & OUT_MSK)))
      else $error("corrected result value wrong");

   a_wr_now: assert property (
      sfr_wr_i && sfr_addr_i == `ADCCS_ADDR_GAIN_HIGH && !cal_done_i
      |=> gain_coef_o[23:16] == $past(sfr_wdata_i))
      else $error("gain high byte write not applied at once");

endmodule : adccs_store

/* verification/tb.sv */
// self-checking bench of the calibration coefficient store
`include "adccs_defines.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adccs_pkg::*;

   typedef struct packed
   {
      adccs_cal_t  kind;
      logic [24:0] val;
      logic [23:0] coef;
      logic        err;
   } adccs_case_t;

   logic        clk_i;
   logic        rst_i;
   logic [7:0]  sfr_addr_i;
   logic        sfr_wr_i;
   logic [7:0]  sfr_wdata_i;
   logic        sfr_rd_i;
   logic [7:0]  sfr_rdata_o;
   logic        cal_done_i;
   adccs_cal_t  cal_kind_i;
   adccs_coef_t cal_offset_i;
   logic [24:0] cal_gain_i;
   logic        err_clr_i;
   logic        converter_error_flag_o;
   logic        conv_valid_i;
   logic [23:0] conv_data_i;
   logic        corr_valid_o;
   logic [23:0] corr_data_o;
   adccs_coef_t offset_coef_o;
   adccs_coef_t gain_coef_o;
   int          err_total = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [23:0] exp_q[$];
   logic        corr16_valid_o;
   logic [15:0] corr16_data_o;
   logic [15:0] exp16_q[$];
   logic [7:0]  addrs [6] = '{`ADCCS_ADDR_OFS_LOW, `ADCCS_ADDR_OFS_MID, `ADCCS_ADDR_OFS_HIGH,
                              `ADCCS_ADDR_GAIN_LOW, `ADCCS_ADDR_GAIN_MID, `ADCCS_ADDR_GAIN_HIGH};
   logic [7:0]  vals [6]  = '{8'h12, 8'h34, 8'hF6, 8'h56, 8'h78, 8'h9A};
   logic [23:0] samples [6] = '{24'h000000, 24'h000010, 24'h7FFFFF, 24'h800000, 24'h123456,
                                24'hFFFFFF};
   logic [23:0] gains [3] = '{24'h940000, 24'hFFFFFF, 24'h000001};
   // both limits of each coefficient, and values just inside all but the upper gain limit
   adccs_case_t cases [9] = '{
      '{ADCCS_CAL_OFFSET, 25'h07FFFFF, 24'h7FFFFF, 1'b1},
      '{ADCCS_CAL_OFFSET, 25'h0800000, 24'h800000, 1'b1},
      '{ADCCS_CAL_OFFSET, 25'h07FFFFE, 24'h7FFFFE, 1'b0},
      '{ADCCS_CAL_OFFSET, 25'h0800001, 24'h800001, 1'b0},
      '{ADCCS_CAL_GAIN,   25'h1000000, 24'hFFFFFF, 1'b1},
      '{ADCCS_CAL_GAIN,   25'h0FFFFFF, 24'hFFFFFF, 1'b1},
      '{ADCCS_CAL_GAIN,   25'h0000000, 24'h000000, 1'b1},
      '{ADCCS_CAL_GAIN,   25'h0940000, 24'h940000, 1'b0},
      '{ADCCS_CAL_GAIN,   25'h0000001, 24'h000001, 1'b0}};

   adccs_store #(.DATA_W(24)) adccs_store_inst
   (
      .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
      .cal_done_i(cal_done_i), .cal_kind_i(cal_kind_i), .cal_offset_i(cal_offset_i),
      .cal_gain_i(cal_gain_i), .err_clr_i(err_clr_i),
      .converter_error_flag_o(converter_error_flag_o), .conv_valid_i(conv_valid_i),
      .conv_data_i(conv_data_i), .corr_valid_o(corr_valid_o), .corr_data_o(corr_data_o),
      .offset_coef_o(offset_coef_o), .gain_coef_o(gain_coef_o)
   );

   // narrow variant on the same register traffic, fed the top 16 bits of each sample
   adccs_store #(.DATA_W(16)) adccs_store_w16_inst
   (
      .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(),
      .cal_done_i(cal_done_i), .cal_kind_i(cal_kind_i), .cal_offset_i(cal_offset_i),
      .cal_gain_i(cal_gain_i), .err_clr_i(err_clr_i), .converter_error_flag_o(),
      .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i[23:8]),
      .corr_valid_o(corr16_valid_o), .corr_data_o(corr16_data_o),
      .offset_coef_o(), .gain_coef_o()
   );

   //////////////////////////////////////////////////////////////////////////////
   // clock, hang guard and result monitor
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         err_total++;
         give_verdict();
      end
   end

   // sampled mid-cycle so the outcome never races the design's flops
   always @(negedge clk_i)
   begin
      if (!rst_i && corr_valid_o === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(corr_data_o, ~corr_data_o);
         else
            chk(corr_data_o, exp_q.pop_front());
      end
      if (!rst_i && corr16_valid_o === 1'b1)
      begin
         if (exp16_q.size() == 0)
            chk({8'h0, corr16_data_o}, {8'h0, ~corr16_data_o});
         else
            chk({8'h0, corr16_data_o}, {8'h0, exp16_q.pop_front()});
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // comparison, access tasks and reference arithmetic
   task automatic chk(input logic [23:0] act, input logic [23:0] exp);
      check_count++;
      if (act !== exp)
      begin
         err_total++;
         $display("unexpected value at %0t: got %h, expected %h", $time, act, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
      sfr_wdata_i <= ~d;
      #1;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i   <= 1'b0;
      #1;
      chk({16'h0, sfr_rdata_o}, {16'h0, e});
   endtask : rd_chk

   // the unused result input carries junk so a wrong select shows
   task automatic cal(input adccs_cal_t k, input logic [24:0] v, input logic clr);
      @(posedge clk_i);
      cal_done_i   <= 1'b1;
      err_clr_i    <= clr;
      cal_kind_i   <= k;
      cal_offset_i <= (k == ADCCS_CAL_OFFSET) ? v[23:0] : ~v[23:0];
      cal_gain_i   <= (k == ADCCS_CAL_GAIN) ? v : {1'b0, ~v[23:0]};
      @(posedge clk_i);
      cal_done_i   <= 1'b0;
      err_clr_i    <= 1'b0;
      #1;
   endtask : cal

   task automatic clear_err;
      @(posedge clk_i);
      err_clr_i <= 1'b1;
      @(posedge clk_i);
      err_clr_i <= 1'b0;
      #1;
   endtask : clear_err

   function automatic logic [23:0] corr_model(input logic [23:0] d, input logic [23:0] o,
                                               input logic [23:0] g);
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      diff = $signed({d[23], d}) - $signed({o[23], o});
      prod = diff * $signed({1'b0, g});
      prod = prod >>> 23;
      if (prod > 50'sh7FFFFF)
         return 24'h7FFFFF;
      if (prod < -50'sh800000)
         return 24'h800000;
      return prod[23:0];
   endfunction : corr_model

   // back-to-back samples, then a bounded wait for all results
   task automatic conv_burst(input logic [23:0] o, input logic [23:0] g);
      logic [23:0] e16;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk_i);
         conv_valid_i <= 1'b1;
         conv_data_i  <= samples[i];
         exp_q.push_back(corr_model(samples[i], o, g));
         // narrow code sits above eight fraction bits; result keeps the top 16 bits
         e16 = corr_model({samples[i][23:8], 8'h00}, o, g);
         exp16_q.push_back(e16[23:8]);
      end
      @(posedge clk_i);
      conv_valid_i <= 1'b0;
      for (int n = 0; n < 10 && exp_q.size() != 0; n++)
         @(posedge clk_i);
      chk(24'(exp_q.size()), 24'h0);
      chk(24'(exp16_q.size()), 24'h0);
   endtask : conv_burst

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   //////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rst_i = 1'b1;
      {sfr_addr_i, sfr_wr_i, sfr_wdata_i, sfr_rd_i, cal_done_i, err_clr_i} = '0;
      cal_kind_i = ADCCS_CAL_OFFSET;
      {cal_offset_i, cal_gain_i, conv_valid_i, conv_data_i} = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk(offset_coef_o, `ADCCS_OFFSET_RST);
      chk(gain_coef_o, `ADCCS_GAIN_RST);
      rd_chk(`ADCCS_ADDR_GAIN_HIGH, 8'h80);
      for (int i = 0; i < 6; i++)
         wr_reg(addrs[i], vals[i]);
      wr_reg(8'hA6, 8'hFF);
      for (int i = 0; i < 6; i++)
         rd_chk(addrs[i], vals[i]);
      rd_chk(8'hA6, `ADCCS_RD_UNMAPPED);
      chk(offset_coef_o, 24'hF63412);
      chk(gain_coef_o, 24'h9A7856);
      wr_reg(`ADCCS_ADDR_OFS_MID, 8'h00);
      chk(offset_coef_o, 24'hF60012);
      $display("test register access done");
      for (int i = 0; i < 9; i++)
      begin
         clear_err();
         chk({23'h0, converter_error_flag_o}, 24'h0);
         cal(cases[i].kind, cases[i].val, 1'b0);
         chk(cases[i].kind == ADCCS_CAL_GAIN ? gain_coef_o : offset_coef_o,
             cases[i].coef);
         chk({23'h0, converter_error_flag_o}, {23'h0, cases[i].err});
      end
      rd_chk(`ADCCS_ADDR_GAIN_LOW, 8'h01);
      clear_err();
      cal(ADCCS_CAL_OFFSET, 25'h0800000, 1'b1);
      chk({23'h0, converter_error_flag_o}, 24'h1);
      $display("test calibration limits done");
      for (int j = 0; j < 6; j++)
      begin
         cal(ADCCS_CAL_OFFSET, (j < 3) ? 25'h0000010 : 25'h0FFFFF0, 1'b0);
         cal(ADCCS_CAL_GAIN, {1'b0, gains[j % 3]}, 1'b0);
         conv_burst((j < 3) ? 24'h000010 : 24'hFFFFF0, gains[j % 3]);
      end
      // only the high byte changes; middle and low still hold the last gain, 000001
      wr_reg(`ADCCS_ADDR_GAIN_HIGH, 8'h40);
      conv_burst(24'hFFFFF0, 24'h400001);
      $display("test correction datapath done");
      give_verdict();
   end

endmodule : tb
